// ### src/bcduc_counter.sv
// Reversible BCD decade counter with preset, terminal flag and ripple pulse.
// Assumes all inputs are pins sampled by the 100 MHz system clock.
//
// Behaviour
// - The count lives in four flip-flops and steps through 8421 BCD values 0 to 9.
// - While parallel_load_n is low, preset_value is copied to the count and shown.
// - The preset acts without any count clock edge, at any time.
// - A low parallel_load_n overrides gate, direction and count clock.
// - With gate and load both high, the count holds across clock edges.
// - With gate low and load high, the count moves only on a rising count clock.
// - Direction low counts up and high counts down, sampled at the rising edge.
// - terminal_flag is high at 9 counting up or 0 counting down, low otherwise.
// - terminal_flag stays high until the count or the direction changes.
// - ripple_pulse_n is high while gate is high or terminal_flag is low.
// - With gate low and flag high, ripple_pulse_n falls at the clock fall until it rises.
`timescale 1ns/1ps
module bcduc_counter
    import bcduc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic count_clock_in,
    input wire logic count_gate_n_in,
    input wire logic direction_select_in,
    input wire logic parallel_load_n_in,
    input wire logic [3:0] preset_value_in,
    output logic [3:0] count_value_out,
    output logic terminal_flag_out,
    output logic ripple_pulse_n_out
);
    logic [7:0] pins_async;
    logic [7:0] pins_sync;
    logic [3:0] preset_s;
    logic dir_s;
    logic gate_n_s;
    logic load_n_s;
    logic cp_s;
    logic cp_prev;
    logic cp_rise;
    logic cp_fall;
    logic [3:0] next_count;
    logic next_flag;
    logic next_ripple_n;

    // Up step; any non-decimal code falls straight back to zero
    function automatic logic [3:0] step_up(input logic [3:0] v);
        if (v >= BCDUC_MAX)
            return BCDUC_MIN;
        return 4'(v + 4'h1);
    endfunction

    // Down step; non-decimal codes walk down into nine
    function automatic logic [3:0] step_down(input logic [3:0] v);
        if (v == BCDUC_MIN)
            return BCDUC_MAX;
        return 4'(v - 4'h1);
    endfunction

    function automatic logic flag_of(input logic [3:0] v, input logic dir);
        return (dir == BCDUC_DIR_UP) ? (v == BCDUC_MAX) : (v == BCDUC_MIN);
    endfunction

    // setup and hold
    // Pins are double-flopped; gate and direction may move in any clock phase
    assign pins_async = {count_clock_in, parallel_load_n_in, count_gate_n_in,
                         direction_select_in, preset_value_in};

    bcduc_sync #(
        .WIDTH(BCDUC_SYNC_W),
        .RESET_VALUE(BCDUC_SYNC_RST)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign preset_s = pins_sync[BCDUC_POS_PRESET +: 4];
    assign dir_s = pins_sync[BCDUC_POS_DIR];
    assign gate_n_s = pins_sync[BCDUC_POS_GATE];
    assign load_n_s = pins_sync[BCDUC_POS_LOAD];
    assign cp_s = pins_sync[BCDUC_POS_CLK];
    assign cp_rise = cp_s & ~cp_prev;
    assign cp_fall = ~cp_s & cp_prev;

    always_comb
    begin
        next_count = count_value_out;
        // preset overrides
        // Preset needs no count clock edge, only the sampled load level
        if (!load_n_s)
            next_count = preset_s;
        else if (!gate_n_s && cp_rise)
        begin
            if (dir_s == BCDUC_DIR_UP)
                next_count = step_up(count_value_out);
            else
                next_count = step_down(count_value_out);
        end
        // flag decode
        // Registered, so the pin never shows decoding spikes
        next_flag = flag_of(next_count, dir_s);
        next_ripple_n = ripple_pulse_n_out;
        if (gate_n_s || !next_flag)
            next_ripple_n = 1'b1;
        else if (cp_fall)
            next_ripple_n = 1'b0;
        else if (cp_rise)
            next_ripple_n = 1'b1;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cp_prev <= 1'b0;
            count_value_out <= BCDUC_RST_COUNT;
            terminal_flag_out <= 1'b0;
            ripple_pulse_n_out <= 1'b1;
        end
        else
        begin
            cp_prev <= cp_s;
            count_value_out <= next_count;
            terminal_flag_out <= next_flag;
            ripple_pulse_n_out <= next_ripple_n;
        end
    end

    property p_load;
        @(posedge clk_sys_in) disable iff (rst_in)
        !load_n_s |=> count_value_out == $past(preset_s);
    endproperty
    a_load: assert property (p_load) else $error("preset not loaded");

    property p_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && gate_n_s |=> $stable(count_value_out);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while gated off");

    property p_edge_only;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && !cp_rise |=> $stable(count_value_out);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("count moved without edge");

    property p_up;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && !gate_n_s && cp_rise && !dir_s && count_value_out < BCDUC_MAX
        |=> count_value_out == 4'($past(count_value_out) + 4'h1);
    endproperty
    a_up: assert property (p_up) else $error("up step wrong");

    property p_down;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && !gate_n_s && cp_rise && dir_s && count_value_out != BCDUC_MIN
        |=> count_value_out == 4'($past(count_value_out) - 4'h1);
    endproperty
    a_down: assert property (p_down) else $error("down step wrong");

    property p_wrap;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && !gate_n_s && cp_rise && dir_s && count_value_out == BCDUC_MIN
        |=> count_value_out == BCDUC_MAX;
    endproperty
    a_wrap: assert property (p_wrap) else $error("down wrap wrong");

    property p_recover;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_n_s && !gate_n_s && cp_rise && !dir_s && count_value_out >= BCDUC_MAX
        |=> count_value_out == BCDUC_MIN;
    endproperty
    a_recover: assert property (p_recover) else $error("up from 9 or above wrong");

    property p_flag;
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 terminal_flag_out == ($past(dir_s) ? (count_value_out == BCDUC_MIN)
                                               : (count_value_out == BCDUC_MAX));
    endproperty
    a_flag: assert property (p_flag) else $error("terminal flag wrong");

    property p_ripple_idle;
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 ($past(gate_n_s) || !terminal_flag_out) |-> ripple_pulse_n_out;
    endproperty
    a_ripple_idle: assert property (p_ripple_idle) else $error("ripple low when idle");

    property p_ripple_low;
        @(posedge clk_sys_in) disable iff (rst_in)
        !gate_n_s && cp_fall ##1 terminal_flag_out |-> !ripple_pulse_n_out;
    endproperty
    a_ripple_low: assert property (p_ripple_low) else $error("ripple pulse missing");

    property p_ripple_rise;
        @(posedge clk_sys_in) disable iff (rst_in)
        !gate_n_s && cp_rise |=> ripple_pulse_n_out;
    endproperty
    a_ripple_rise: assert property (p_ripple_rise) else $error("ripple past rise");

    property p_ripple_keep;
        @(posedge clk_sys_in) disable iff (rst_in)
        !ripple_pulse_n_out && !gate_n_s && !cp_rise ##1 terminal_flag_out
        |-> !ripple_pulse_n_out;
    endproperty
    a_ripple_keep: assert property (p_ripple_keep) else $error("ripple ended early");

    c_load: cover property (@(posedge clk_sys_in) disable iff (rst_in) !load_n_s);
    c_up_wrap: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        count_value_out == BCDUC_MAX ##1 count_value_out == BCDUC_MIN);
    c_down_wrap: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        count_value_out == BCDUC_MIN ##1 count_value_out == BCDUC_MAX);
    c_ripple: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        !ripple_pulse_n_out);
endmodule

// ### src/bcduc_pkg.sv
// Constants shared by the up/down decade counter.
// Assumes a single 100 MHz system clock samples every pin.
package bcduc_pkg;
    localparam int unsigned BCDUC_CNT_W = 4;
    localparam logic [3:0] BCDUC_MAX = 4'h9;
    localparam logic [3:0] BCDUC_MIN = 4'h0;
    localparam logic [3:0] BCDUC_RST_COUNT = 4'h0;
    // Synchroniser vector layout
    localparam int unsigned BCDUC_SYNC_W = 8;
    localparam int unsigned BCDUC_POS_PRESET = 0;
    localparam int unsigned BCDUC_POS_DIR = 4;
    localparam int unsigned BCDUC_POS_GATE = 5;
    localparam int unsigned BCDUC_POS_LOAD = 6;
    localparam int unsigned BCDUC_POS_CLK = 7;
    // Idle pin levels: load and gate inactive high, clock low, up
    localparam logic [7:0] BCDUC_SYNC_RST = 8'h60;
    localparam logic BCDUC_DIR_UP = 1'b0;
endpackage

// ### src/bcduc_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes every bit is a slowly changing level; no bus coherency given.
`timescale 1ns/1ps
module bcduc_sync
    import bcduc_pkg::*;
#(
    parameter int unsigned WIDTH = BCDUC_SYNC_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    always_comb
    begin
        next_stage1 = async_in;
        next_sync = stage1;
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage1 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            stage1 <= next_stage1;
            sync_out <= next_sync;
        end
    end
endmodule

// ### test/bcduc_ctl_model.sv
// Control-logic model that makes one count clock pulse per request.
// Assumes the bench changes gate and direction only while busy_out is low.
`timescale 1ns/1ps
module bcduc_ctl_model
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic step_req_in,
    output logic count_clock_out,
    output logic busy_out
);
    logic [2:0] phase;
    logic [2:0] next_phase;
    always_comb
    begin
        next_phase = phase;
        if (phase != 3'h0)
            next_phase = phase - 3'h1;
        else if (step_req_in)
            next_phase = 3'h6;
    end
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            phase <= 3'h0;
        else
            phase <= next_phase;
    end
    // flag never clocks us
    // Three cycles high then three low, so both synced phases are seen
    assign count_clock_out = (phase > 3'h3);
    assign busy_out = (phase != 3'h0);
endmodule

// ### test/tb.sv
// Self-checking bench for the decade counter against an integer model.
// Assumes the control model drives the count clock; pins settle in 3 cycles.
`timescale 1ns/1ps
module tb
    import bcduc_pkg::*;
;
    logic clk_sys_in, rst_in, step_req, busy, cclk, gate_n, dir, load_n, flag, rip_n;
    logic [3:0] preset, q;
    int mismatches, n_tests, cnt, mg, mdir, ml, k, r, pv;
    bcduc_counter i_bcduc_counter (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .count_clock_in(cclk), .count_gate_n_in(gate_n), .direction_select_in(dir),
        .parallel_load_n_in(load_n), .preset_value_in(preset), .count_value_out(q),
        .terminal_flag_out(flag), .ripple_pulse_n_out(rip_n));
    bcduc_ctl_model i_bcduc_ctl_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .step_req_in(step_req), .count_clock_out(cclk), .busy_out(busy));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Low ripple is only demanded after a clock fall has happened
    task automatic check(input bit after_step);
        logic ef;
        logic er;
        ef = ((mdir == 0) && (cnt == 9)) || ((mdir == 1) && (cnt == 0));
        er = !((mg == 0) && ef);
        n_tests++;
        if (q !== cnt[3:0] || flag !== ef || ((after_step || er) && rip_n !== er))
        begin
            mismatches++;
            $display("[FAIL] %0t count %h flag %b ripple %b exp %0d", $time, q, flag, rip_n, cnt);
        end
    endtask
    task automatic set(input int g, input int d, input int l, input int p);
        @(posedge clk_sys_in)
        begin
            gate_n <= g[0];
            dir <= d[0];
            load_n <= l[0];
            preset <= p[3:0];
        end
        mg = g;
        mdir = d;
        ml = l;
        if (l == 0)
            cnt = p;
        repeat (5) @(posedge clk_sys_in);
        check(1'b0);
    endtask
    task automatic step();
        @(posedge clk_sys_in) step_req <= 1'b1;
        @(posedge clk_sys_in) step_req <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        k = 0;
        while (busy !== 1'b0 && k < 20)
        begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= 20)
        begin
            mismatches++;
            $display("[FAIL] %0t control model stuck", $time);
            finish_test();
        end
        if (mg == 0 && ml == 1)
            cnt = (mdir == 0) ? ((cnt >= 9) ? 0 : cnt + 1) : ((cnt == 0) ? 9 : cnt - 1);
        repeat (4) @(posedge clk_sys_in);
        check(1'b1);
    endtask
    initial
    begin
        void'($urandom(41739));
        mismatches = 0;
        n_tests = 0;
        cnt = 0;
        mdir = 0;
        mg = 1;
        ml = 1;
        rst_in = 1'b1;
        step_req = 1'b0;
        gate_n = 1'b1;
        dir = 1'b0;
        load_n = 1'b1;
        preset = 4'h0;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check(1'b0);
        set(0, 0, 0, 9);
        step();
        set(0, 0, 1, 9);
        step();
        set(0, 1, 1, 0);
        step();
        set(1, 1, 1, 0);
        step();
        set(0, 0, 0, 15);
        set(0, 0, 1, 15);
        step();
        set(0, 1, 0, 12);
        set(0, 1, 1, 12);
        repeat (4) step();
        // Reset in mid-run drops everything at once, pins left as they are
        @(posedge clk_sys_in) rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        n_tests++;
        if (q !== BCDUC_RST_COUNT || flag !== 1'b0 || rip_n !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t reset count %h flag %b ripple %b", $time, q, flag, rip_n);
        end
        rst_in <= 1'b0;
        cnt = 0;
        // Synced direction reaches the flag three edges after release
        repeat (5) @(posedge clk_sys_in);
        check(1'b0);
        repeat (60)
        begin
            r = $urandom_range(0, 7);
            if (r == 0)
            begin
                // Preset stays put while load is released, for its hold time
                pv = $urandom_range(0, 15);
                set(mg, mdir, 0, pv);
                set(mg, mdir, 1, pv);
            end
            else if (r < 3)
                set($urandom_range(0, 1), $urandom_range(0, 1), 1, 0);
            else
                step();
        end
        finish_test();
    end
endmodule
